// ==== core/ptcm_regs.sv ====
/*
 * Thermal-shutdown, analogue mux, clock and interrupt mask register slice.
 * Assumes a serial control front end delivering 16-bit words with an index,
 * analogue event pins and clock pins from outside the clk_i domain, and flag
 * clear strobes from the flag register logic on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module ptcm_regs (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic [2:0] reg_index_i,
	input wire logic reg_write_i,
	input wire logic reg_read_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Fuse default for thermal configuration
	input wire logic [10:0] otp_thermal_config_i,
	// Asynchronous event pins
	input wire logic [7:0] thermal_event_i,
	input wire logic [6:0] overcurrent_event_i,
	// Asynchronous clock pins
	input wire logic sync_input_pin_i,
	input wire logic internal_clock_a_i,
	input wire logic internal_clock_b_i,
	// Flag clear strobes
	input wire logic [7:0] thermal_flag_clear_i,
	input wire logic [6:0] overcurrent_flag_clear_i,
	// Regulator and state machine requests
	output logic [7:0] shutdown_req_o,
	output logic deep_fail_safe_state_o,
	// Status and interrupt
	output logic [7:0] thermal_flags_o,
	output logic [6:0] overcurrent_flags_o,
	output logic irq_o,
	// Analogue configuration
	output logic [7:0] die_temp_limit_c_o,
	output logic die_temp_code_valid_o,
	output logic [4:0] analog_channel_select_o,
	output logic [5:0] analog_ratio_o,
	// Clock configuration
	output logic spread_spectrum_enable_o,
	output logic [13:0] spread_spectrum_rate_10hz_o,
	output logic [3:0] oscillator_trim_o,
	output logic [3:0] freq_output_mux_o,
	output logic sync_to_pll_o,
	output logic freq_output_pin_o,
	output logic [9:0] low_power_clk_khz_o
);
	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Degrees for a temperature code, zero when undefined
	function automatic logic [7:0] temp_of(input logic [2:0] code);
		logic [7:0] prod;
		prod = ptcm_pkg::TEMP_STEP_C * {5'h00, code};
		if (code > ptcm_pkg::TEMP_CODE_MAX) begin
			temp_of = 8'h00;
		end else begin
			temp_of = 8'(ptcm_pkg::TEMP_BASE_C + prod);
		end
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] tsd_r, tsd_nxt; // Thermal configuration
	logic [15:0] analog_channel_select_r, analog_channel_select_nxt; // Analogue mux select
	logic [15:0] internal_clock_a_r, internal_clock_a_nxt; // Primary clock config
	logic [15:0] internal_clock_b_r, internal_clock_b_nxt; // Low-power clock config
	logic [15:0] mask1_r, mask1_nxt; // Interrupt masks
	logic loaded_r, loaded_nxt; // Fuse default taken
	logic [15:0] rdata_r, rdata_nxt; // Read data

	// Next register values
	always_comb begin
		tsd_nxt = tsd_r;
		analog_channel_select_nxt = analog_channel_select_r;
		internal_clock_a_nxt = internal_clock_a_r;
		internal_clock_b_nxt = internal_clock_b_r;
		mask1_nxt = mask1_r;
		loaded_nxt = 1'b1;
		rdata_nxt = rdata_r;
		// Fuse default caught once after reset release
		if (!loaded_r) begin
			tsd_nxt = {5'h00, otp_thermal_config_i};
		end
		// Writes keep only defined bits
		if (reg_write_i) begin
			if (reg_index_i == ptcm_pkg::IDX_THERMAL_SHUTDOWN_CONFIG) begin
				tsd_nxt = reg_wdata_i & ptcm_pkg::WMASK_TSD;
			end else if (reg_index_i == ptcm_pkg::IDX_ANALOG_MUX_SELECT) begin
				analog_channel_select_nxt = reg_wdata_i & ptcm_pkg::WMASK_ANALOG_CHANNEL_SELECT;
			end else if (reg_index_i == ptcm_pkg::IDX_CLOCK_CONFIG_PRIMARY) begin
				internal_clock_a_nxt = reg_wdata_i & ptcm_pkg::WMASK_INTERNAL_CLOCK_A;
			end else if (reg_index_i == ptcm_pkg::IDX_CLOCK_CONFIG_LOW_POWER) begin
				internal_clock_b_nxt = reg_wdata_i & ptcm_pkg::WMASK_INTERNAL_CLOCK_B;
			end else if (reg_index_i == ptcm_pkg::IDX_INTERRUPT_MASK_THERMAL_OVERCURRENT) begin
				mask1_nxt = reg_wdata_i & ptcm_pkg::WMASK_MASK1;
			end
		end
		// Reads, route bit hidden
		if (reg_read_i) begin
			if (reg_index_i == ptcm_pkg::IDX_THERMAL_SHUTDOWN_CONFIG) begin
				rdata_nxt = tsd_r;
			end else if (reg_index_i == ptcm_pkg::IDX_ANALOG_MUX_SELECT) begin
				rdata_nxt = analog_channel_select_r;
			end else if (reg_index_i == ptcm_pkg::IDX_CLOCK_CONFIG_PRIMARY) begin
				rdata_nxt = internal_clock_a_r & ptcm_pkg::RMASK_INTERNAL_CLOCK_A;
			end else if (reg_index_i == ptcm_pkg::IDX_CLOCK_CONFIG_LOW_POWER) begin
				rdata_nxt = internal_clock_b_r;
			end else if (reg_index_i == ptcm_pkg::IDX_INTERRUPT_MASK_THERMAL_OVERCURRENT) begin
				rdata_nxt = mask1_r;
			end else begin
				rdata_nxt = 16'h0000; // Unmapped index
			end
		end
	end

	// Register update
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tsd_r <= 16'h0000;
			analog_channel_select_r <= ptcm_pkg::RST_ANALOG_CHANNEL_SELECT;
			internal_clock_a_r <= ptcm_pkg::RST_INTERNAL_CLOCK_A;
			internal_clock_b_r <= ptcm_pkg::RST_INTERNAL_CLOCK_B;
			mask1_r <= ptcm_pkg::RST_MASK1;
			loaded_r <= 1'b0;
			rdata_r <= 16'h0000;
		end else begin
			tsd_r <= tsd_nxt;
			analog_channel_select_r <= analog_channel_select_nxt;
			internal_clock_a_r <= internal_clock_a_nxt;
			internal_clock_b_r <= internal_clock_b_nxt;
			mask1_r <= mask1_nxt;
			loaded_r <= loaded_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [17:0] raw_w; // All outside pins
	logic [17:0] s1_r, s2_r, s3_r; // Three-stage chains
	logic [17:0] lvl_r, lvl_nxt; // Accepted levels
	logic [17:0] rise_w; // Accepted rising edges
	assign raw_w = {internal_clock_b_i, internal_clock_a_i, sync_input_pin_i,
		overcurrent_event_i, thermal_event_i};

	// Level accepted once stages two and three agree
	always_comb begin
		lvl_nxt = lvl_r;
		rise_w = 18'h00000;
		for (int i = 0; i < ptcm_pkg::N_RAW; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s3_r[i];
				rise_w[i] = s3_r[i] & ~lvl_r[i];
			end
		end
	end

	// Chain registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_r <= 18'h00000;
			s2_r <= 18'h00000;
			s3_r <= 18'h00000;
			lvl_r <= 18'h00000;
		end else begin
			s1_r <= raw_w;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	// ----------------------------------------
	// Events, flags and outputs
	// ----------------------------------------
	logic [7:0] tsd_ev_w; // Thermal trip pulses
	logic [6:0] oc_ev_w; // Overcurrent pulses
	logic sel_clk_w; // Chosen internal clock
	logic [7:0] tap_w; // Delay line taps
	assign tsd_ev_w = rise_w[7:0];
	assign oc_ev_w = rise_w[14:8];
	assign sel_clk_w = internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_SOURCE_BIT] ? lvl_r[17] : lvl_r[16];
	logic [7:0] tflag_r, tflag_nxt;
	logic [6:0] oflag_r, oflag_nxt;
	logic [7:0] sreq_r, sreq_nxt;
	logic dfs_r, dfs_nxt, irq_r, irq_nxt;
	logic [1:0] div_cnt_r, div_cnt_nxt; // Sync edge counter
	logic div_r, div_nxt; // Divided sync
	logic pll_r, pll_nxt;
	logic [6:0] dly_r, dly_nxt; // Delay line
	logic freq_output_pin_r, freq_output_pin_nxt;
	logic [7:0] temp_r, temp_nxt;
	logic tvalid_r, tvalid_nxt;
	logic [5:0] ratio_r, ratio_nxt;
	logic [13:0] ss_rate_r, ss_rate_nxt;
	logic [9:0] lp_r, lp_nxt;
	assign tap_w = {dly_r, sel_clk_w};

	// Next output values
	always_comb begin
		// Set wins over clear
		tflag_nxt = (tflag_r & ~thermal_flag_clear_i) | tsd_ev_w;
		oflag_nxt = (oflag_r & ~overcurrent_flag_clear_i) | oc_ev_w;
		// Shutdown always, fail-safe only with config bit
		sreq_nxt = tsd_ev_w;
		dfs_nxt = |(tsd_ev_w & tsd_r[7:0]);
		// Unmasked flags hold the interrupt
		// Thermal masks sit rotated by one against the event order
		irq_nxt = |(tflag_r & ~{mask1_r[6:0], mask1_r[7]}) |
			|(oflag_r & ~{mask1_r[ptcm_pkg::MASK1_HV_OC_BIT], mask1_r[13:8]});
		// Divide by six: toggle every third rising edge
		div_cnt_nxt = div_cnt_r;
		div_nxt = div_r;
		if (rise_w[15]) begin
			if (div_cnt_r == ptcm_pkg::SYNC_DIV_HALF) begin
				div_cnt_nxt = 2'h0;
				div_nxt = ~div_r;
			end else begin
				div_cnt_nxt = 2'(div_cnt_r + 2'h1);
			end
		end
		// Route to PLL only when enabled
		if (!internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_TO_PLL_BIT]) begin
			pll_nxt = 1'b0;
		end else if (internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_DIVIDER_BIT]) begin
			pll_nxt = div_r;
		end else begin
			pll_nxt = lvl_r[15];
		end
		// Delay by phase count
		dly_nxt = tap_w[6:0];
		freq_output_pin_nxt = tap_w[internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_DELAY_LSB +: 3]];
		// Temperature threshold
		temp_nxt = temp_of(tsd_r[ptcm_pkg::TSD_TEMP_LSB +: 3]);
		tvalid_nxt = tsd_r[ptcm_pkg::TSD_TEMP_LSB +: 3] <= ptcm_pkg::TEMP_CODE_MAX;
		// Divider ratio
		ratio_nxt = analog_channel_select_r[ptcm_pkg::ANALOG_CHANNEL_SELECT_RATIO_BIT] ? ptcm_pkg::RATIO_HIGH :
			ptcm_pkg::RATIO_LOW;
		// Modulation rate
		ss_rate_nxt = internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_PROFILE_BIT] ? ptcm_pkg::SS_RATE_HIGH_10HZ :
			ptcm_pkg::SS_RATE_LOW_10HZ;
		// Low-power clock
		case (internal_clock_b_r[1:0])
			2'h2: begin
				lp_nxt = ptcm_pkg::LP_CLK_300_KHZ;
			end
			2'h3: begin
				lp_nxt = ptcm_pkg::LP_CLK_600_KHZ;
			end
			default: begin
				lp_nxt = ptcm_pkg::LP_CLK_100_KHZ;
			end
		endcase
	end

	// Output registers
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tflag_r <= 8'h00;
			oflag_r <= 7'h00;
			sreq_r <= 8'h00;
			dfs_r <= 1'b0;
			irq_r <= 1'b0;
			div_cnt_r <= 2'h0;
			div_r <= 1'b0;
			pll_r <= 1'b0;
			dly_r <= 7'h00;
			freq_output_pin_r <= 1'b0;
			temp_r <= 8'h00;
			tvalid_r <= 1'b0;
			ratio_r <= 6'h00;
			ss_rate_r <= 14'h0000;
			lp_r <= 10'h000;
		end else begin
			tflag_r <= tflag_nxt;
			oflag_r <= oflag_nxt;
			sreq_r <= sreq_nxt;
			dfs_r <= dfs_nxt;
			irq_r <= irq_nxt;
			div_cnt_r <= div_cnt_nxt;
			div_r <= div_nxt;
			pll_r <= pll_nxt;
			dly_r <= dly_nxt;
			freq_output_pin_r <= freq_output_pin_nxt;
			temp_r <= temp_nxt;
			tvalid_r <= tvalid_nxt;
			ratio_r <= ratio_nxt;
			ss_rate_r <= ss_rate_nxt;
			lp_r <= lp_nxt;
		end
	end

	// Ports straight from flip-flops
	assign reg_rdata_o = rdata_r;
	assign shutdown_req_o = sreq_r;
	assign deep_fail_safe_state_o = dfs_r;
	assign thermal_flags_o = tflag_r;
	assign overcurrent_flags_o = oflag_r;
	assign irq_o = irq_r;
	assign die_temp_limit_c_o = temp_r;
	assign die_temp_code_valid_o = tvalid_r;
	assign analog_channel_select_o = analog_channel_select_r[4:0];
	assign analog_ratio_o = ratio_r;
	assign spread_spectrum_enable_o = internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_SS_EN_BIT];
	assign spread_spectrum_rate_10hz_o = ss_rate_r;
	assign oscillator_trim_o = internal_clock_a_r[3:0];
	assign freq_output_mux_o = internal_clock_a_r[ptcm_pkg::INTERNAL_CLOCK_A_MUX_LSB +: 4];
	assign sync_to_pll_o = pll_r;
	assign freq_output_pin_o = freq_output_pin_r;
	assign low_power_clk_khz_o = lp_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	AST_DFS_ON_CFG: assert property ((|(tsd_ev_w & tsd_r[7:0])) |=> deep_fail_safe_state_o)
		else $error("Fail-safe not raised");
	AST_SHUTDOWN_ONLY: assert property ((|tsd_ev_w) && !(|(tsd_ev_w & tsd_r[7:0]))
		|=> (shutdown_req_o == $past(tsd_ev_w)) && !deep_fail_safe_state_o)
		else $error("Wrong thermal action");
	AST_TEMP_VALID: assert property ($past(reset_n_i) |-> die_temp_code_valid_o ==
		($past(tsd_r[10:8]) <= 3'h5))
		else $error("Temperature validity wrong");
	AST_RATIO: assert property ($past(reset_n_i) |->
		analog_ratio_o == ($past(analog_channel_select_r[5]) ? 6'h22 : 6'h14))
		else $error("Divider ratio wrong");
	AST_ROUTE_HIDDEN: assert property (reg_read_i && reg_index_i == 3'h2
		|=> !reg_rdata_o[6])
		else $error("Route bit visible");
	AST_PLL_GATE: assert property (!internal_clock_a_r[6] |=> !sync_to_pll_o)
		else $error("Sync reached PLL");
	AST_LP_CLK: assert property (##1 (internal_clock_b_r[1:0] == 2'h3) |=> low_power_clk_khz_o == 10'h258)
		else $error("Low-power clock wrong");
	AST_RESERVED: assert property (reg_read_i && reg_index_i == 3'h3
		|=> reg_rdata_o[15:2] == 14'h0000)
		else $error("Reserved bits nonzero");
	AST_IRQ_THERMAL: assert property ((|(tflag_r & ~{mask1_r[6:0], mask1_r[7]})) |=> irq_o)
		else $error("Thermal interrupt lost");
	AST_IRQ_OC: assert property ((|(oflag_r & ~{mask1_r[15], mask1_r[13:8]})) |=> irq_o)
		else $error("Overcurrent interrupt lost");
	AST_IRQ_HOLD: assert property (irq_o && $stable(tflag_r) && $stable(oflag_r)
		&& $stable(mask1_r) |=> irq_o)
		else $error("Interrupt dropped");
	AST_NO_DELAY: assert property (internal_clock_a_r[10:8] == 3'h0 |=> freq_output_pin_o == $past(sel_clk_w))
		else $error("Zero delay path wrong");
endmodule
`default_nettype wire

// ==== core/ptcm_pkg.sv ====
/*
 * Package for the thermal, clock and mask register slice.
 * Holds register indices, field positions, write masks and decode values.
 * Assumes the serial control interface outside presents decoded 16-bit words.
 */
package ptcm_pkg;
	// ----------------------------------------
	// Register indices
	// ----------------------------------------
	localparam logic [2:0] IDX_THERMAL_SHUTDOWN_CONFIG = 3'h0;
	localparam logic [2:0] IDX_ANALOG_MUX_SELECT = 3'h1;
	localparam logic [2:0] IDX_CLOCK_CONFIG_PRIMARY = 3'h2;
	localparam logic [2:0] IDX_CLOCK_CONFIG_LOW_POWER = 3'h3;
	localparam logic [2:0] IDX_INTERRUPT_MASK_THERMAL_OVERCURRENT = 3'h4;
	// ----------------------------------------
	// Writable bits per register, others read zero
	// ----------------------------------------
	localparam logic [15:0] WMASK_TSD = 16'h07ff;
	localparam logic [15:0] WMASK_ANALOG_CHANNEL_SELECT = 16'h003f;
	localparam logic [15:0] WMASK_INTERNAL_CLOCK_A = 16'hffff;
	localparam logic [15:0] RMASK_INTERNAL_CLOCK_A = 16'hffbf;
	localparam logic [15:0] WMASK_INTERNAL_CLOCK_B = 16'h0003;
	localparam logic [15:0] WMASK_MASK1 = 16'hbfff;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_ANALOG_CHANNEL_SELECT = 16'h0000;
	localparam logic [15:0] RST_INTERNAL_CLOCK_A = 16'h0000;
	localparam logic [15:0] RST_INTERNAL_CLOCK_B = 16'h0000;
	localparam logic [15:0] RST_MASK1 = 16'h0000;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TSD_TEMP_LSB = 8;
	localparam int ANALOG_CHANNEL_SELECT_RATIO_BIT = 5;
	localparam int INTERNAL_CLOCK_A_PROFILE_BIT = 15;
	localparam int INTERNAL_CLOCK_A_MUX_LSB = 11;
	localparam int INTERNAL_CLOCK_A_DELAY_LSB = 8;
	localparam int INTERNAL_CLOCK_A_SOURCE_BIT = 7;
	localparam int INTERNAL_CLOCK_A_TO_PLL_BIT = 6;
	localparam int INTERNAL_CLOCK_A_DIVIDER_BIT = 5;
	localparam int INTERNAL_CLOCK_A_SS_EN_BIT = 4;
	localparam int MASK1_HV_OC_BIT = 15;
	localparam int MASK1_OC_LSB = 8;
	// ----------------------------------------
	// Decode values
	// ----------------------------------------
	localparam logic [7:0] TEMP_BASE_C = 8'h4b;
	localparam logic [7:0] TEMP_STEP_C = 8'h0f;
	localparam logic [2:0] TEMP_CODE_MAX = 3'h5;
	localparam logic [5:0] RATIO_LOW = 6'h14;
	localparam logic [5:0] RATIO_HIGH = 6'h22;
	localparam logic [13:0] SS_RATE_LOW_10HZ = 14'h090b;
	localparam logic [13:0] SS_RATE_HIGH_10HZ = 14'h242c;
	localparam logic [9:0] LP_CLK_100_KHZ = 10'h064;
	localparam logic [9:0] LP_CLK_300_KHZ = 10'h12c;
	localparam logic [9:0] LP_CLK_600_KHZ = 10'h258;
	localparam logic [1:0] SYNC_DIV_HALF = 2'h2;
	localparam int N_TSD = 8;
	localparam int N_OC = 7;
	localparam int N_RAW = 18;
endpackage

// ==== testbench/ptcm_regs_tb.sv ====
/*
 * Self-checking bench for the thermal, clock and mask register slice.
 * Assumes ptcm_regs alone on one 50 MHz clock; the bench drives every
 * register, event, clock and clear pin itself, with no partner model.
 */
`timescale 1ns/1ns
`default_nettype none
module ptcm_regs_tb;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [2:0] reg_index_i = 3'h0;
	logic reg_write_i = 1'b0;
	logic reg_read_i = 1'b0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [10:0] otp_thermal_config_i = 11'h2a5; // Code 2, mixed actions
	logic [7:0] thermal_event_i = 8'h00;
	logic [6:0] overcurrent_event_i = 7'h00;
	logic sync_input_pin_i = 1'b0;
	logic internal_clock_a_i = 1'b0;
	logic internal_clock_b_i = 1'b0;
	logic [7:0] thermal_flag_clear_i = 8'h00;
	logic [6:0] overcurrent_flag_clear_i = 7'h00;
	logic [15:0] reg_rdata_o;
	logic [7:0] shutdown_req_o, thermal_flags_o, die_temp_limit_c_o;
	logic [6:0] overcurrent_flags_o;
	logic deep_fail_safe_state_o, irq_o, die_temp_code_valid_o;
	logic [4:0] analog_channel_select_o;
	logic [5:0] analog_ratio_o;
	logic spread_spectrum_enable_o, sync_to_pll_o, freq_output_pin_o;
	logic [13:0] spread_spectrum_rate_10hz_o;
	logic [3:0] oscillator_trim_o, freq_output_mux_o;
	logic [9:0] low_power_clk_khz_o;
	// Readback after all-ones writes, index 0..7
	logic [15:0] acc [8] = '{16'h07ff, 16'h003f, 16'hffbf, 16'h0003, 16'hbfff, 16'h0, 16'h0, 16'h0};
	// Low-power clock in kHz per code
	logic [15:0] lp [4] = '{16'h0064, 16'h0064, 16'h012c, 16'h0258};
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int d0, d7, n;

	// Free-running 50 MHz clock
	always #10 clk_i = ~clk_i;

	ptcm_regs ptcm_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_index_i(reg_index_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .otp_thermal_config_i(otp_thermal_config_i),
		.thermal_event_i(thermal_event_i), .overcurrent_event_i(overcurrent_event_i),
		.sync_input_pin_i(sync_input_pin_i), .internal_clock_a_i(internal_clock_a_i),
		.internal_clock_b_i(internal_clock_b_i), .thermal_flag_clear_i(thermal_flag_clear_i),
		.overcurrent_flag_clear_i(overcurrent_flag_clear_i), .shutdown_req_o(shutdown_req_o),
		.deep_fail_safe_state_o(deep_fail_safe_state_o), .thermal_flags_o(thermal_flags_o),
		.overcurrent_flags_o(overcurrent_flags_o), .irq_o(irq_o),
		.die_temp_limit_c_o(die_temp_limit_c_o), .die_temp_code_valid_o(die_temp_code_valid_o),
		.analog_channel_select_o(analog_channel_select_o), .analog_ratio_o(analog_ratio_o),
		.spread_spectrum_enable_o(spread_spectrum_enable_o),
		.spread_spectrum_rate_10hz_o(spread_spectrum_rate_10hz_o),
		.oscillator_trim_o(oscillator_trim_o), .freq_output_mux_o(freq_output_mux_o),
		.sync_to_pll_o(sync_to_pll_o), .freq_output_pin_o(freq_output_pin_o),
		.low_power_clk_khz_o(low_power_clk_khz_o));

	// ----------------------------------------
	// Compare, report and hang guard
	// ----------------------------------------
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task test_done;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short well past the expected run length
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end

	// ----------------------------------------
	// Register port and pin helpers
	// ----------------------------------------
	// One-cycle write strobe
	task wr(input logic [2:0] idx, input logic [15:0] data);
		@(posedge clk_i);
		reg_write_i <= 1'b1;
		reg_index_i <= idx;
		reg_wdata_i <= data;
		@(posedge clk_i);
		reg_write_i <= 1'b0;
	endtask

	// One-cycle read strobe, data looked at one cycle later
	task rdchk(input logic [2:0] idx, input logic [15:0] exp);
		@(posedge clk_i);
		reg_read_i <= 1'b1;
		reg_index_i <= idx;
		@(posedge clk_i);
		reg_read_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("read data", exp, reg_rdata_o);
	endtask

	// Lets registered decoders follow a write
	task settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask

	// Pulses flag clear strobes
	task clr(input logic [7:0] t, input logic [6:0] o);
		@(posedge clk_i);
		thermal_flag_clear_i <= t;
		overcurrent_flag_clear_i <= o;
		@(posedge clk_i);
		thermal_flag_clear_i <= 8'h00;
		overcurrent_flag_clear_i <= 7'h00;
		settle();
	endtask

	// Raises one clock pin, counts cycles to the output rise (20 = none)
	task meas(input logic [1:0] which, output int cnt);
		@(posedge clk_i);
		internal_clock_a_i <= which[0];
		internal_clock_b_i <= which[1];
		cnt = 0;
		while (cnt < 20 && freq_output_pin_o !== 1'b1) begin
			@(posedge clk_i);
			#1;
			cnt++;
		end
		@(posedge clk_i);
		internal_clock_a_i <= 1'b0;
		internal_clock_b_i <= 1'b0;
		repeat (30) @(posedge clk_i);
	endtask

	// Twelve sync pin periods, counts rises seen on the PLL input
	task pll(output int r);
		logic prev;
		r = 0;
		prev = sync_to_pll_o;
		for (int k = 0; k < 120; k++) begin
			@(posedge clk_i);
			sync_input_pin_i <= (k < 96) ? k[2] : 1'b0;
			#1;
			if (sync_to_pll_o === 1'b1 && prev === 1'b0) r++;
			prev = sync_to_pll_o;
		end
	endtask

	// Thermal event on one regulator, pulse and flag checked
	task tev(input int i, input logic deep_fail_safe_state);
		logic [7:0] b;
		b = 8'h01 << i;
		@(posedge clk_i);
		thermal_event_i <= b;
		n = 0;
		while (n < 10 && shutdown_req_o === 8'h00) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("shutdown req", 16'(b), 16'(shutdown_req_o));
		chk("fail safe", 16'(deep_fail_safe_state), 16'(deep_fail_safe_state_o));
		@(posedge clk_i);
		#1;
		chk("shutdown pulse end", 16'h0000, 16'(shutdown_req_o));
		chk("thermal flag", 16'(b), 16'(thermal_flags_o));
		@(posedge clk_i);
		thermal_event_i <= 8'h00;
		settle();
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		// Reset values
		rdchk(3'h0, 16'(otp_thermal_config_i));
		for (int i = 1; i < 5; i++) rdchk(3'(i), 16'h0000);
		// Writable bits, write-only bit and reserved places
		for (int i = 0; i < 8; i++) wr(3'(i), 16'hffff);
		for (int i = 0; i < 8; i++) rdchk(3'(i), acc[i]);
		for (int i = 0; i < 8; i++) wr(3'(i), 16'h0000);
		// Temperature decode, every code
		for (int c = 0; c < 8; c++) begin
			wr(3'h0, {5'h00, 3'(c), 8'h08});
			settle();
			chk("temp", (c < 6) ? 16'h004b + 16'(c) * 16'h000f : 16'h0000, 16'(die_temp_limit_c_o));
			chk("temp valid", 16'(c < 6), 16'(die_temp_code_valid_o));
		end
		// Divider ratio and channel
		wr(3'h1, 16'h0000);
		settle();
		chk("ratio", 16'h0014, 16'(analog_ratio_o));
		wr(3'h1, 16'h0025);
		settle();
		chk("ratio", 16'h0022, 16'(analog_ratio_o));
		chk("channel", 16'h0005, 16'(analog_channel_select_o));
		// Low-power clock codes
		for (int c = 0; c < 4; c++) begin
			wr(3'h3, 16'(c));
			settle();
			chk("low power clk", lp[c], 16'(low_power_clk_khz_o));
		end
		// Primary clock fields and spread spectrum
		wr(3'h2, 16'h5a0c);
		settle();
		chk("trim", 16'h000c, 16'(oscillator_trim_o));
		chk("out mux", 16'h000b, 16'(freq_output_mux_o));
		chk("ss enable", 16'h0000, 16'(spread_spectrum_enable_o));
		wr(3'h2, 16'h0010);
		settle();
		chk("ss enable", 16'h0001, 16'(spread_spectrum_enable_o));
		chk("ss rate", 16'h090b, 16'(spread_spectrum_rate_10hz_o));
		wr(3'h2, 16'h8010);
		settle();
		chk("ss rate", 16'h242c, 16'(spread_spectrum_rate_10hz_o));
		// Sync input route and divider
		wr(3'h2, 16'h0000);
		pll(n);
		chk("pll rises off", 16'h0000, 16'(n));
		wr(3'h2, 16'h0040);
		pll(n);
		chk("pll rises div1", 16'h000c, 16'(n));
		wr(3'h2, 16'h0060);
		pll(n);
		chk("pll rises div6", 16'h0002, 16'(n));
		rdchk(3'h2, 16'h0020);
		// Output source and delay
		wr(3'h2, 16'h0000);
		meas(2'b01, d0);
		meas(2'b10, n);
		chk("source a ignores b", 16'h0014, 16'(n));
		wr(3'h2, 16'h0700);
		meas(2'b01, d7);
		chk("delay 7", 16'h0007, 16'(d7 - d0));
		wr(3'h2, 16'h0080);
		meas(2'b01, n);
		chk("source b ignores a", 16'h0014, 16'(n));
		meas(2'b10, n);
		chk("source b", 16'(d0), 16'(n));
		// Thermal events, masks and clears
		tev(3, 1'b1);
		chk("irq", 16'h0001, 16'(irq_o));
		wr(3'h4, 16'h0004);
		settle();
		chk("irq masked", 16'h0000, 16'(irq_o));
		wr(3'h4, 16'h0000);
		settle();
		chk("irq unmasked", 16'h0001, 16'(irq_o));
		clr(8'h08, 7'h00);
		chk("irq cleared", 16'h0000, 16'(irq_o));
		tev(2, 1'b0);
		clr(8'h04, 7'h00);
		wr(3'h4, 16'h0080);
		tev(0, 1'b0);
		chk("irq masked", 16'h0000, 16'(irq_o));
		clr(8'h01, 7'h00);
		// Overcurrent event, masked then unmasked
		wr(3'h4, 16'h8000);
		@(posedge clk_i);
		overcurrent_event_i <= 7'h40;
		settle();
		settle();
		chk("oc flag", 16'h0040, 16'(overcurrent_flags_o));
		chk("oc irq masked", 16'h0000, 16'(irq_o));
		wr(3'h4, 16'h0000);
		settle();
		chk("oc irq", 16'h0001, 16'(irq_o));
		@(posedge clk_i);
		overcurrent_event_i <= 7'h00;
		clr(8'h00, 7'h40);
		chk("oc irq cleared", 16'h0000, 16'(irq_o));
		test_done();
	end
endmodule
`default_nettype wire
